/* hdl/busy_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module busy_timer #(
  parameter int unsigned CNT_W = 15
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic load_in,
  input wire logic [CNT_W-1:0] count_in,
  output logic busy_out
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_in) begin
      cnt_nxt = count_in;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy_out = (cnt_r != '0);
endmodule // busy_timer
`default_nettype wire

/* hdl/i2c_ctl_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
// turns a byte stream from the i2c receiver into host words
module i2c_ctl_decoder (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic flush_in,
  input wire logic start_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  output lcd_gate_pkg::host_word_t word_out
);
  typedef enum logic [1:0] {WAIT_ADDR, WAIT_CTL, WAIT_CMD, STREAM} rx_state_t;
  rx_state_t st_r;
  rx_state_t st_nxt;
  logic rsel_r;
  logic rsel_nxt;
  lcd_gate_pkg::host_word_t word_r;
  lcd_gate_pkg::host_word_t word_nxt;

  always_comb begin
    st_nxt = st_r;
    rsel_nxt = rsel_r;
    word_nxt = '0;
    if (flush_in) begin
      st_nxt = WAIT_ADDR;
    end else if (start_in) begin
      st_nxt = WAIT_ADDR;
    end else if (byte_valid_in) begin
      unique case (st_r)
        WAIT_ADDR: st_nxt = WAIT_CTL;
        WAIT_CTL: begin
          // low six bits must be zero; a bad control byte drops the frame
          if (byte_in[5:0] != 6'h00) begin
            st_nxt = WAIT_ADDR;
          end else begin
            rsel_nxt = byte_in[lcd_gate_pkg::CTL_RSEL_BIT];
            st_nxt = byte_in[lcd_gate_pkg::CTL_MORE_BIT] ? WAIT_CMD : STREAM;
          end
        end
        WAIT_CMD: begin
          word_nxt = '{valid: 1'b1, reg_sel: rsel_r, data: byte_in};
          st_nxt = WAIT_CTL;
        end
        STREAM: word_nxt = '{valid: 1'b1, reg_sel: rsel_r, data: byte_in};
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_r <= WAIT_ADDR;
      rsel_r <= 1'b0;
      word_r <= '0;
    end else begin
      st_r <= st_nxt;
      rsel_r <= rsel_nxt;
      word_r <= word_nxt;
    end
  end

  assign word_out = word_r;
endmodule // i2c_ctl_decoder
`default_nettype wire

/* hdl/lcd_gate_pkg.sv */
package lcd_gate_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  // busy span after power-on, in microseconds
  localparam int unsigned INIT_BUSY_US = 2000;
  localparam int unsigned INIT_BUSY_CYC = (INIT_BUSY_US * (CLK_HZ / 1_000_000));
  localparam int unsigned CLEAR_CYC = 165;
  localparam int unsigned XFER_CYC = 3;
  localparam int unsigned CMD_CYC = 3;

  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] ADDR_RST = 7'h00;

  // i2c control byte layout
  localparam int unsigned CTL_MORE_BIT = 7;
  localparam int unsigned CTL_RSEL_BIT = 6;

  typedef struct packed {
    logic address_step_up;
    logic pan_on_write;
    logic panel_visible;
    logic underline_on;
    logic cursor_flashing;
    logic bus_width_select;
    logic two_row_select;
    logic extended_page;
    logic single_row_select;
    logic glyph_target;
    logic icons_enable;
    logic icon_flash;
    logic direct_drive;
    logic cfg_bit_one;
    logic cfg_bit_two;
    logic cfg_bit_three;
    logic temp_coef_bit1;
    logic temp_coef_bit2;
    logic gen_level_a;
    logic gen_level_b;
    logic stage_sel_hi;
    logic stage_sel_lo;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RST = '{
    address_step_up: 1'b1, pan_on_write: 1'b0, panel_visible: 1'b0,
    underline_on: 1'b0, cursor_flashing: 1'b0, bus_width_select: 1'b1,
    two_row_select: 1'b0, extended_page: 1'b0, single_row_select: 1'b0,
    glyph_target: 1'b0, icons_enable: 1'b0, icon_flash: 1'b0,
    direct_drive: 1'b0, cfg_bit_one: 1'b0, cfg_bit_two: 1'b0,
    cfg_bit_three: 1'b0, temp_coef_bit1: 1'b0, temp_coef_bit2: 1'b0,
    gen_level_a: 1'b0, gen_level_b: 1'b0, stage_sel_hi: 1'b1,
    stage_sel_lo: 1'b0};

  // one host write, from either bus
  typedef struct packed {
    logic valid;
    logic reg_sel;
    logic [7:0] data;
  } host_word_t;

  typedef enum logic [3:0] {
    STEP_CLEAR, STEP_ENTRY, STEP_DISPLAY, STEP_FUNCTION, STEP_ADDRESS,
    STEP_ICON, STEP_SCREEN, STEP_COEF, STEP_GEN, STEP_IFACE, STEP_MULT,
    STEP_DONE
  } init_step_t;

endpackage

/* hdl/lcd_reset_and_command_gate.sv */
// Contract
// - power-up runs reset on its own, with clear lasting 165 cycles; at power-up the clear step loads the INIT_CYC span instead
// - reset sets increment, no shift, display, underline and flashing off
// - reset selects 8-bit bus, one row, normal page, mux 1:18
// - reset points the address at display text ram
// - busy stays high from reset for 2 ms of initialization
// - host instruction sequence may reach the same state instead
// - reset clears icons, icon flash and direct drive
// - reset clears the three screen configuration bits
// - reset clears both temperature coefficient bits
// - reset turns generator off and picks multiplier factor 4
// - host reaches only the command and data holding registers
// - control byte: more-follow top, reg select next, six zero bits
// - each ram data write steps address by one per direction
// - shift on entry happens with the data write itself
// - while busy only status reads are served
// - busy is high while an instruction executes, low afterwards
// - instructions arriving while busy are discarded
// - status read gives busy on top, address below, no cycles
// - ram data access occupies the device for 3 cycles
`timescale 1ns/1ps
`default_nettype none
module lcd_reset_and_command_gate #(
  parameter int unsigned INIT_CYC = lcd_gate_pkg::INIT_BUSY_CYC
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic par_valid_in,
  input wire logic par_reg_sel_in,
  input wire logic [7:0] par_data_in,
  input wire logic i2c_start_in,
  input wire logic i2c_byte_valid_in,
  input wire logic [7:0] i2c_byte_in,
  output logic [7:0] status_out,
  output logic busy_indicator_out,
  output lcd_gate_pkg::ctrl_state_t ctrl_out,
  output logic [6:0] address_pointer_out,
  output logic [7:0] command_holding_out,
  output logic [7:0] write_data_holding_out,
  output logic ram_write_out,
  output logic [6:0] ram_addr_out,
  output logic display_clear_out,
  output logic display_shift_out,
  output logic shift_right_out
);
  localparam int unsigned CNT_W = (INIT_CYC > 255) ? $clog2(INIT_CYC + 1) : 8;
  // the registered flag adds the load cycle, so the timer holds one cycle less than the span
  localparam logic [CNT_W-1:0] CLEAR_LD = CNT_W'(lcd_gate_pkg::CLEAR_CYC - 1);
  localparam logic [CNT_W-1:0] XFER_LD = CNT_W'(lcd_gate_pkg::XFER_CYC - 1);
  localparam logic [CNT_W-1:0] CMD_LD = CNT_W'(lcd_gate_pkg::CMD_CYC - 1);
  localparam logic [CNT_W-1:0] INIT_LD = CNT_W'(INIT_CYC - 1);

  lcd_gate_pkg::init_step_t step_r;
  lcd_gate_pkg::init_step_t step_nxt;
  lcd_gate_pkg::ctrl_state_t ctrl_r;
  lcd_gate_pkg::ctrl_state_t ctrl_nxt;
  logic [6:0] addr_r;
  logic [6:0] addr_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [7:0] wdat_r;
  logic [7:0] wdat_nxt;
  logic ramwr_r;
  logic ramwr_nxt;
  logic [6:0] ramaddr_r;
  logic [6:0] ramaddr_nxt;
  logic clear_r;
  logic clear_nxt;
  logic shift_r;
  logic shift_nxt;
  logic sright_r;
  logic sright_nxt;
  logic [7:0] stat_r;
  logic load;
  logic [CNT_W-1:0] load_cnt;
  logic busy;
  logic init_busy;
  logic i2c_flush;
  lcd_gate_pkg::host_word_t i2c_word;
  lcd_gate_pkg::host_word_t req;

  // execution timer: power-on span first, then per-instruction spans
  busy_timer #(.CNT_W(CNT_W)) u_timer (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .load_in(load),
    .count_in(load_cnt),
    .busy_out(busy)
  );

  assign i2c_flush = (step_r == lcd_gate_pkg::STEP_IFACE);

  i2c_ctl_decoder u_i2c (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .flush_in(i2c_flush),
    .start_in(i2c_start_in),
    .byte_valid_in(i2c_byte_valid_in),
    .byte_in(i2c_byte_in),
    .word_out(i2c_word)
  );

  // parallel bus has priority if both buses present a word together
  always_comb begin
    req = i2c_word;
    if (par_valid_in) begin
      req = '{valid: 1'b1, reg_sel: par_reg_sel_in, data: par_data_in};
    end
  end

  assign init_busy = (step_r != lcd_gate_pkg::STEP_DONE);

  always_comb begin
    step_nxt = step_r;
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    wdat_nxt = wdat_r;
    ramwr_nxt = 1'b0;
    ramaddr_nxt = ramaddr_r;
    clear_nxt = 1'b0;
    shift_nxt = 1'b0;
    sright_nxt = sright_r;
    load = 1'b0;
    load_cnt = CMD_LD;
    unique case (step_r)
      lcd_gate_pkg::STEP_CLEAR: begin
        clear_nxt = 1'b1;
        addr_nxt = lcd_gate_pkg::ADDR_RST;
        load = 1'b1;
        load_cnt = INIT_LD;
        step_nxt = lcd_gate_pkg::STEP_ENTRY;
      end
      lcd_gate_pkg::STEP_ENTRY: begin
        ctrl_nxt.address_step_up = lcd_gate_pkg::CTRL_RST.address_step_up;
        ctrl_nxt.pan_on_write = lcd_gate_pkg::CTRL_RST.pan_on_write;
        step_nxt = lcd_gate_pkg::STEP_DISPLAY;
      end
      lcd_gate_pkg::STEP_DISPLAY: begin
        ctrl_nxt.panel_visible = lcd_gate_pkg::CTRL_RST.panel_visible;
        ctrl_nxt.underline_on = lcd_gate_pkg::CTRL_RST.underline_on;
        ctrl_nxt.cursor_flashing = lcd_gate_pkg::CTRL_RST.cursor_flashing;
        step_nxt = lcd_gate_pkg::STEP_FUNCTION;
      end
      lcd_gate_pkg::STEP_FUNCTION: begin
        ctrl_nxt.bus_width_select = lcd_gate_pkg::CTRL_RST.bus_width_select;
        ctrl_nxt.two_row_select = lcd_gate_pkg::CTRL_RST.two_row_select;
        ctrl_nxt.extended_page = lcd_gate_pkg::CTRL_RST.extended_page;
        ctrl_nxt.single_row_select = lcd_gate_pkg::CTRL_RST.single_row_select;
        step_nxt = lcd_gate_pkg::STEP_ADDRESS;
      end
      lcd_gate_pkg::STEP_ADDRESS: begin
        ctrl_nxt.glyph_target = lcd_gate_pkg::CTRL_RST.glyph_target;
        step_nxt = lcd_gate_pkg::STEP_ICON;
      end
      lcd_gate_pkg::STEP_ICON: begin
        ctrl_nxt.icons_enable = lcd_gate_pkg::CTRL_RST.icons_enable;
        ctrl_nxt.icon_flash = lcd_gate_pkg::CTRL_RST.icon_flash;
        ctrl_nxt.direct_drive = lcd_gate_pkg::CTRL_RST.direct_drive;
        step_nxt = lcd_gate_pkg::STEP_SCREEN;
      end
      lcd_gate_pkg::STEP_SCREEN: begin
        ctrl_nxt.cfg_bit_one = lcd_gate_pkg::CTRL_RST.cfg_bit_one;
        ctrl_nxt.cfg_bit_two = lcd_gate_pkg::CTRL_RST.cfg_bit_two;
        ctrl_nxt.cfg_bit_three = lcd_gate_pkg::CTRL_RST.cfg_bit_three;
        step_nxt = lcd_gate_pkg::STEP_COEF;
      end
      lcd_gate_pkg::STEP_COEF: begin
        ctrl_nxt.temp_coef_bit1 = lcd_gate_pkg::CTRL_RST.temp_coef_bit1;
        ctrl_nxt.temp_coef_bit2 = lcd_gate_pkg::CTRL_RST.temp_coef_bit2;
        step_nxt = lcd_gate_pkg::STEP_GEN;
      end
      lcd_gate_pkg::STEP_GEN: begin
        ctrl_nxt.gen_level_a = lcd_gate_pkg::CTRL_RST.gen_level_a;
        ctrl_nxt.gen_level_b = lcd_gate_pkg::CTRL_RST.gen_level_b;
        step_nxt = lcd_gate_pkg::STEP_IFACE;
      end
      lcd_gate_pkg::STEP_IFACE: step_nxt = lcd_gate_pkg::STEP_MULT;
      lcd_gate_pkg::STEP_MULT: begin
        ctrl_nxt.stage_sel_hi = lcd_gate_pkg::CTRL_RST.stage_sel_hi;
        ctrl_nxt.stage_sel_lo = lcd_gate_pkg::CTRL_RST.stage_sel_lo;
        step_nxt = lcd_gate_pkg::STEP_DONE;
      end
      lcd_gate_pkg::STEP_DONE: begin
        // anything arriving while busy is dropped here unexecuted
        // gate on the flag the host sees, so no word is taken while it still reads busy
        if (req.valid && !busy && !stat_r[7]) begin
          load = 1'b1;
          if (req.reg_sel) begin
            wdat_nxt = req.data;
            ramwr_nxt = 1'b1;
            ramaddr_nxt = addr_r;
            load_cnt = XFER_LD;
            addr_nxt = ctrl_r.address_step_up ? 7'(addr_r + 7'h01) : 7'(addr_r - 7'h01);
            if (ctrl_r.pan_on_write && !ctrl_r.glyph_target) begin
              shift_nxt = 1'b1;
              sright_nxt = !ctrl_r.address_step_up;
            end
          end else begin
            cmd_nxt = req.data;
            load_cnt = CMD_LD;
            // only the plain-page clear, entry and display commands and the
            // function command on either page are decoded; the rest just occupy the timer
            if (!ctrl_r.extended_page && req.data == 8'h01) begin
              clear_nxt = 1'b1;
              addr_nxt = lcd_gate_pkg::ADDR_RST;
              ctrl_nxt.address_step_up = 1'b1;
              ctrl_nxt.glyph_target = 1'b0;
              load_cnt = CLEAR_LD;
            end else if (!ctrl_r.extended_page && req.data[7:2] == 6'h01) begin
              ctrl_nxt.address_step_up = req.data[1];
              ctrl_nxt.pan_on_write = req.data[0];
            end else if (!ctrl_r.extended_page && req.data[7:3] == 5'h01) begin
              ctrl_nxt.panel_visible = req.data[2];
              ctrl_nxt.underline_on = req.data[1];
              ctrl_nxt.cursor_flashing = req.data[0];
            end else if (req.data[7:5] == 3'h1 && !req.data[3]) begin
              ctrl_nxt.bus_width_select = req.data[4];
              ctrl_nxt.two_row_select = req.data[2];
              ctrl_nxt.single_row_select = req.data[1];
              ctrl_nxt.extended_page = req.data[0];
            end
          end
        end
      end
      default: step_nxt = lcd_gate_pkg::STEP_DONE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      step_r <= lcd_gate_pkg::STEP_CLEAR;
      ctrl_r <= lcd_gate_pkg::CTRL_RST;
      addr_r <= lcd_gate_pkg::ADDR_RST;
      cmd_r <= 8'h00;
      wdat_r <= 8'h00;
      ramwr_r <= 1'b0;
      ramaddr_r <= 7'h00;
      clear_r <= 1'b0;
      shift_r <= 1'b0;
      sright_r <= 1'b0;
      stat_r <= 8'h80;
    end else begin
      step_r <= step_nxt;
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      wdat_r <= wdat_nxt;
      ramwr_r <= ramwr_nxt;
      ramaddr_r <= ramaddr_nxt;
      clear_r <= clear_nxt;
      shift_r <= shift_nxt;
      sright_r <= sright_nxt;
      stat_r <= {(busy || init_busy || load), addr_nxt};
    end
  end

  assign status_out = stat_r;
  assign busy_indicator_out = stat_r[7];
  assign ctrl_out = ctrl_r;
  assign address_pointer_out = addr_r;
  assign command_holding_out = cmd_r;
  assign write_data_holding_out = wdat_r;
  assign ram_write_out = ramwr_r;
  assign ram_addr_out = ramaddr_r;
  assign display_clear_out = clear_r;
  assign display_shift_out = shift_r;
  assign shift_right_out = sright_r;
endmodule // lcd_reset_and_command_gate
`default_nettype wire

/* tb/lcd_gate_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_gate_sva #(
  parameter int unsigned INIT_CYC = 20
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic par_valid_in,
  input wire logic [7:0] status_out,
  input wire logic busy_indicator_out,
  input wire lcd_gate_pkg::ctrl_state_t ctrl_out,
  input wire logic [6:0] address_pointer_out,
  input wire logic [7:0] command_holding_out,
  input wire logic [7:0] write_data_holding_out,
  input wire logic ram_write_out,
  input wire logic [6:0] ram_addr_out,
  input wire logic display_clear_out,
  input wire logic display_shift_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // cycles since reset release, saturating
  logic [15:0] up_r;
  logic [15:0] up_nxt;
  always_comb up_nxt = (up_r == 16'hffff) ? up_r : up_r + 16'h0001;
  always_ff @(posedge mclk_in) up_r <= srst_in ? 16'h0000 : up_nxt;
  property p_status; status_out == {busy_indicator_out, address_pointer_out}; endproperty
  a_status: assert property (p_status) else $error("status byte mismatch");
  property p_rst; $fell(srst_in) |-> ctrl_out == lcd_gate_pkg::CTRL_RST && status_out == 8'h80; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_clear; $fell(srst_in) |-> ##[0:2] display_clear_out; endproperty
  a_clear: assert property (p_clear) else $error("no clear after reset");
  property p_init; up_r < 16'(INIT_CYC) |-> busy_indicator_out; endproperty
  a_init: assert property (p_init) else $error("busy dropped during init");
  property p_step;
    ram_write_out |-> address_pointer_out ==
      (ctrl_out.address_step_up ? ram_addr_out + 7'h01 : ram_addr_out - 7'h01);
  endproperty
  a_step: assert property (p_step) else $error("address step wrong");
  property p_xfer; ram_write_out |-> busy_indicator_out [*3] ##1 !busy_indicator_out; endproperty
  a_xfer: assert property (p_xfer) else $error("transfer busy span wrong");
  property p_shift; display_shift_out |-> ram_write_out; endproperty
  a_shift: assert property (p_shift) else $error("shift apart from write");
  property p_drop;
    par_valid_in && busy_indicator_out |=> $stable(command_holding_out) && $stable(write_data_holding_out);
  endproperty
  a_drop: assert property (p_drop) else $error("word taken while busy");
  property p_take; par_valid_in && !busy_indicator_out |=> busy_indicator_out; endproperty
  a_take: assert property (p_take) else $error("busy not raised");
  c_write: cover property (ram_write_out);
  c_shift: cover property (display_shift_out);
  c_clear: cover property (display_clear_out);
endmodule // lcd_gate_sva
bind lcd_reset_and_command_gate lcd_gate_sva #(.INIT_CYC(INIT_CYC)) lcd_gate_sva_i (
  .mclk_in(mclk_in), .srst_in(srst_in), .par_valid_in(par_valid_in), .status_out(status_out),
  .busy_indicator_out(busy_indicator_out), .ctrl_out(ctrl_out), .address_pointer_out(address_pointer_out),
  .command_holding_out(command_holding_out), .write_data_holding_out(write_data_holding_out),
  .ram_write_out(ram_write_out), .ram_addr_out(ram_addr_out), .display_clear_out(display_clear_out),
  .display_shift_out(display_shift_out));
`default_nettype wire

/* tb/lcd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
  input wire logic mclk_in,
  input wire logic busy_in,
  output logic par_valid_out,
  output logic par_reg_sel_out,
  output logic [7:0] par_data_out,
  output logic i2c_start_out,
  output logic i2c_byte_valid_out,
  output logic [7:0] i2c_byte_out,
  output logic late_out
);
  initial begin
    par_valid_out = 1'b0;
    par_reg_sel_out = 1'b0;
    par_data_out = 8'h00;
    i2c_start_out = 1'b0;
    i2c_byte_valid_out = 1'b0;
    i2c_byte_out = 8'h00;
    late_out = 1'b0;
  end
  task automatic put_byte(input logic [7:0] b);
    i2c_byte_out <= b;
    i2c_byte_valid_out <= 1'b1;
    @(posedge mclk_in);
    i2c_byte_valid_out <= 1'b0;
    // released lines show the inverse so a stale byte never looks fresh
    i2c_byte_out <= ~b;
    @(posedge mclk_in);
  endtask
  // mode 0 parallel, 1 i2c, 2 i2c with a bad control byte, 3 i2c with more-follow set
  task automatic send(input logic rs, input logic [7:0] d, input int mode, input bit chk);
    int n;
    n = 0;
    while (chk && busy_in !== 1'b0 && n < 500) begin
      @(posedge mclk_in);
      n++;
    end
    if (n == 500) late_out <= 1'b1;
    if (mode == 0) begin
      par_reg_sel_out <= rs;
      par_data_out <= d;
      par_valid_out <= 1'b1;
      @(posedge mclk_in);
      par_valid_out <= 1'b0;
      par_data_out <= ~d;
      @(posedge mclk_in);
    end else begin
      i2c_start_out <= 1'b1;
      @(posedge mclk_in);
      i2c_start_out <= 1'b0;
      put_byte(8'h74);
      put_byte({1'(mode == 3), rs, 5'h00, 1'(mode == 2)});
      put_byte(d);
    end
  endtask
endmodule // lcd_host_model
`default_nettype wire

/* tb/lcd_reset_and_command_gate_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_reset_and_command_gate_bench;
  localparam int unsigned INIT = 20;
  logic mclk_in, srst_in, pv, prs, i2s, i2v, late, busy, ram_wr, clr, shf, shr;
  logic [7:0] pd, i2b, status, cmd_hold, wd_hold;
  logic [6:0] addr, ram_addr, exp_addr, step;
  lcd_gate_pkg::ctrl_state_t ctrl;
  int err_count, total_checks, shifts, n;
  logic [31:0] seed;
  logic [14:0] notes[$];
  lcd_reset_and_command_gate #(.INIT_CYC(INIT)) lcd_reset_and_command_gate_i (
    .mclk_in(mclk_in), .srst_in(srst_in), .par_valid_in(pv), .par_reg_sel_in(prs), .par_data_in(pd),
    .i2c_start_in(i2s), .i2c_byte_valid_in(i2v), .i2c_byte_in(i2b), .status_out(status),
    .busy_indicator_out(busy), .ctrl_out(ctrl), .address_pointer_out(addr), .command_holding_out(cmd_hold),
    .write_data_holding_out(wd_hold), .ram_write_out(ram_wr), .ram_addr_out(ram_addr),
    .display_clear_out(clr), .display_shift_out(shf), .shift_right_out(shr));
  lcd_host_model lcd_host_model_i (
    .mclk_in(mclk_in), .busy_in(busy), .par_valid_out(pv), .par_reg_sel_out(prs), .par_data_out(pd),
    .i2c_start_out(i2s), .i2c_byte_valid_out(i2v), .i2c_byte_out(i2b), .late_out(late));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task results;
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task wait_idle;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (busy !== 1'b0 && n < 400);
    if (n >= 400) begin
      err_count++;
      results;
    end
  endtask
  task wr(input logic [7:0] v, input int mode);
    notes.push_back({exp_addr, v});
    lcd_host_model_i.send(1'b1, v, mode, 1'b1);
    exp_addr = exp_addr + step;
    wait_idle;
  endtask
  task cmd(input logic [7:0] v);
    lcd_host_model_i.send(1'b0, v, 0, 1'b1);
    wait_idle;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  // a write result pops the oldest expected address and data
  always @(posedge mclk_in) begin
    if (late === 1'b1) begin
      err_count++;
      results;
    end
    if (srst_in === 1'b0 && ram_wr === 1'b1) begin
      if (shf === 1'b1 && shr === 1'b1) shifts++;
      if (notes.size() == 0) check(32'h1, 32'h0);
      else check(32'({ram_addr, wd_hold}), 32'(notes.pop_front()));
    end
  end
  initial begin
    seed = 32'ha00e_cadc;
    err_count = 0;
    total_checks = 0;
    shifts = 0;
    srst_in = 1'b1;
    exp_addr = 7'h00;
    step = 7'h01;
    repeat (12) @(posedge mclk_in);
    check(32'(status), 32'h0000_0080);
    srst_in <= 1'b0;
    wait_idle;
    check(32'(n >= INIT), 32'h1);
    check(32'(ctrl), 32'(lcd_gate_pkg::CTRL_RST));
    check(32'({ctrl.address_step_up, ctrl.pan_on_write, ctrl.panel_visible, ctrl.bus_width_select,
      ctrl.extended_page, ctrl.single_row_select, ctrl.glyph_target, ctrl.icons_enable,
      ctrl.temp_coef_bit1, ctrl.gen_level_a, ctrl.stage_sel_hi, ctrl.stage_sel_lo, ctrl.cfg_bit_one}),
      32'h0000_1204);
    for (int i = 0; i < 4; i++) begin
      wr(rnd(), 0);
      check(n, 3);
    end
    // second word lands while the first still executes
    notes.push_back({exp_addr, 8'h55});
    lcd_host_model_i.send(1'b1, 8'h55, 0, 1'b1);
    lcd_host_model_i.send(1'b1, 8'haa, 0, 1'b0);
    exp_addr = exp_addr + step;
    wait_idle;
    check(32'(wd_hold), 32'h0000_0055);
    cmd(8'h05);
    step = 7'h7f;
    wr(rnd(), 0);
    check(shifts, 1);
    check(32'(addr), 32'(exp_addr));
    cmd(8'h06);
    step = 7'h01;
    wr(rnd(), 1);
    wr(rnd(), 3);
    lcd_host_model_i.send(1'b1, 8'h33, 2, 1'b1);
    wait_idle;
    check(32'(addr), 32'(exp_addr));
    cmd(8'h0f);
    check(32'(cmd_hold), 32'h0000_000f);
    check(32'({ctrl.panel_visible, ctrl.underline_on, ctrl.cursor_flashing}), 32'h7);
    cmd(8'h36);
    check(32'({ctrl.bus_width_select, ctrl.two_row_select, ctrl.single_row_select, ctrl.extended_page}),
      32'he);
    cmd(8'h30);
    cmd(8'h08);
    cmd(8'h06);
    cmd(8'h01);
    check(n, 165);
    check(32'(ctrl), 32'(lcd_gate_pkg::CTRL_RST));
    check(32'(addr), 32'h0);
    exp_addr = 7'h00;
    wr(rnd(), 0);
    // reset lands in mid-execution of a write
    notes.push_back({exp_addr, 8'h3c});
    lcd_host_model_i.send(1'b1, 8'h3c, 0, 1'b1);
    srst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    check(32'(status), 32'h0000_0080);
    srst_in <= 1'b0;
    notes.delete();
    exp_addr = 7'h00;
    wait_idle;
    check(32'(ctrl), 32'(lcd_gate_pkg::CTRL_RST));
    wr(rnd(), 1);
    check(notes.size(), 0);
    results;
  end
endmodule // lcd_reset_and_command_gate_bench
`default_nettype wire
